/* rtl/uotg_pkg.sv */
// uotg_pkg: register map, field positions and timing for the otg status block
// assumes a 40 MHz ref_clk and 32-bit avalon-mm register access
package uotg_pkg;
   // register byte offsets
   localparam logic [3:0] UOTG_OFS_FLAGS  = 4'h0;
   localparam logic [3:0] UOTG_OFS_STATUS = 4'h4;
   // field positions, shared by flags and live status except timer and act, which are flags only
   localparam int UOTG_BIT_ID     = 7;
   localparam int UOTG_BIT_TIMER  = 6;
   localparam int UOTG_BIT_LINE   = 5;
   localparam int UOTG_BIT_ACT    = 4;
   localparam int UOTG_BIT_SESSION_VALID_STATUS  = 3;
   localparam int UOTG_BIT_B_SESSION_END_STATUS = 2;
   localparam int UOTG_BIT_AVBUS  = 0;
   // implemented bits of each register
   localparam logic [7:0] UOTG_FLAG_MASK   = 8'hFD;
   localparam logic [7:0] UOTG_STATUS_MASK = 8'hAD;
   localparam logic [7:0] UOTG_RESET_VAL   = 8'h00;
   localparam logic [31:0] UOTG_ZERO_WORD  = 32'h0000_0000;
   // one millisecond in clock cycles
   localparam int UOTG_CLK_HZ      = 40_000_000;
   localparam int UOTG_MS_US       = 1000;
   localparam int UOTG_MS_CYCLES   = (UOTG_CLK_HZ / 1_000_000) * UOTG_MS_US;
   localparam int UOTG_CNT_W       = 16;
   // number of synchronised inputs: id, session_valid_status, b_session_end_status, avbus, dp, dm
   localparam int UOTG_NSYNC       = 6;
   // positions inside the synchronised cable vector
   localparam int UOTG_PIN_ID     = 3;
   localparam int UOTG_PIN_SESSION_VALID_STATUS  = 2;
   localparam int UOTG_PIN_B_SESSION_END_STATUS = 1;
   localparam int UOTG_PIN_AVBUS  = 0;
   // enabled cycles after reset before cable edges count; covers the sync latency
   localparam int UOTG_SETTLE_CYCLES = 6;
endpackage : uotg_pkg

/* rtl/uotg_sync.sv */
// uotg_sync: three-flop synchroniser bank with agreement filter
// assumes asynchronous pin levels; output changes once stages two and three agree
`timescale 1ns/1ps
module uotg_sync
   import uotg_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   // meta_q feeds only s2_q
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta_q <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
      end else if (clk_en) begin
         meta_q <= async_in;
         s2_q   <= meta_q;
         s3_q   <= s2_q;
      end
   end

   // filtered level, updated per bit only on agreement
   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_agree
         always_ff @(posedge ref_clk) begin
            if (srst) begin
               sync_out[g] <= 1'b0;
            end else if (clk_en && (s2_q[g] == s3_q[g])) begin
               sync_out[g] <= s3_q[g];
            end
         end
      end
   endgenerate
endmodule : uotg_sync

/* rtl/uotg_ms_timer.sv */
// uotg_ms_timer: free-running one millisecond tick generator
// assumes clk_en gates time; tick is a pulse of one enabled cycle
`timescale 1ns/1ps
module uotg_ms_timer
   import uotg_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic clk_en,
   output logic      ms_tick
);
   localparam logic [UOTG_CNT_W-1:0] LAST = UOTG_CNT_W'(UOTG_MS_CYCLES - 1);
   logic [UOTG_CNT_W-1:0] cnt_q;

   // count 0..LAST, pulse on wrap; the tick holds while frozen so it is never lost
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_q   <= '0;
         ms_tick <= 1'b0;
      end else if (clk_en) begin
         ms_tick <= (cnt_q == LAST);
         cnt_q   <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
      end
   end
endmodule : uotg_ms_timer

/* rtl/uotg_status.sv */
// uotg_status: usb otg live status and sticky change flags behind avalon-mm
// assumes cable comparator and pin levels are asynchronous; se0/j come from the usb core
`timescale 1ns/1ps
module uotg_status
   import uotg_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        clk_en,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // cable side levels
   input  wire logic        id_pin,
   input  wire logic        session_valid_in,
   input  wire logic        session_end_in,
   input  wire logic        a_vbus_valid_in,
   input  wire logic        dp_pin,
   input  wire logic        dm_pin,
   // line state from the usb core, same clock
   input  wire logic        line_se0,
   input  wire logic        line_j_level,
   input  wire logic        sleeping
);
   logic [3:0]  pin_sync;
   logic        ms_tick;
   logic        id_s;
   logic        session_valid_status_s;
   logic        b_session_end_status_s;
   logic        avbus_s;
   logic [3:0]  pin_prev_q;
   logic [1:0]  line_prev_q;
   logic [1:0]  line_rec_q;
   logic [1:0]  dpm_sync;
   logic [1:0]  dpm_prev_q;
   logic        line_moved_q;
   logic        line_stable_status_q;
   logic [7:0]  flags_q;
   logic [7:0]  flags_d;
   logic [7:0]  status_w;
   logic [7:0]  set_w;
   logic [7:0]  clr_w;
   logic        ack_q;
   logic        wake_w;
   logic [2:0]  settle_q;
   logic        armed_w;
   logic [3:0]  pin_edge_w;
   logic [1:0]  line_now_w;
   logic        line_step_w;

   // decode of a register word offset
   function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   // pin levels pass four flops, three sync stages and the agreement filter; order id, session_valid_status, b_session_end_status, avbus
   uotg_sync #(.WIDTH(4)) u_sync_cable (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .async_in ({id_pin, session_valid_in, session_end_in, a_vbus_valid_in}),
      .sync_out (pin_sync)
   );

   // data lines only feed activity detection
   uotg_sync #(.WIDTH(2)) u_sync_data (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .async_in ({dp_pin, dm_pin}),
      .sync_out (dpm_sync)
   );

   uotg_ms_timer u_timer (
      .ref_clk (ref_clk),
      .srst    (srst),
      .clk_en  (clk_en),
      .ms_tick (ms_tick)
   );

   assign id_s     = pin_sync[UOTG_PIN_ID];
   assign session_valid_status_s  = pin_sync[UOTG_PIN_SESSION_VALID_STATUS];
   assign b_session_end_status_s = pin_sync[UOTG_PIN_B_SESSION_END_STATUS];
   assign avbus_s  = pin_sync[UOTG_PIN_AVBUS];

   // edges stay masked until the sync chain holds real pin levels after reset;
   // otherwise a pin idling high would look like a change right after reset
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         settle_q <= '0;
      end else if (clk_en && !armed_w) begin
         settle_q <= settle_q + 3'h1;
      end
   end

   assign armed_w = (settle_q == 3'(UOTG_SETTLE_CYCLES));

   // one edge detector per cable level
   genvar gi;
   generate
      for (gi = 0; gi < $bits(pin_sync); gi++) begin : g_edge
         assign pin_edge_w[gi] = armed_w && (pin_sync[gi] != pin_prev_q[gi]);
      end
   endgenerate

   // current line state and a move since the last cycle
   assign line_now_w  = {line_se0, line_j_level};
   assign line_step_w = (line_prev_q != line_now_w);

   // previous synchronised levels for edge compare
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_prev_q <= '0;
         dpm_prev_q <= '0;
      end else if (clk_en) begin
         pin_prev_q <= pin_sync;
         dpm_prev_q <= dpm_sync;
      end
   end

   // line stability over the current millisecond window;
   // a change anywhere in the window spoils it, so the status lags up to 2 ms
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         line_prev_q          <= '0;
         line_moved_q         <= 1'b0;
         line_stable_status_q <= 1'b0;
         line_rec_q           <= '0;
      end else if (clk_en) begin
         line_prev_q <= line_now_w;
         if (ms_tick) begin
            // a move in the tick cycle itself spoils the next window
            line_moved_q         <= line_step_w;
            line_stable_status_q <= !line_moved_q && !line_step_w;
            if (!line_moved_q && !line_step_w) begin
               line_rec_q <= line_prev_q;
            end
         end else if (line_step_w) begin
            line_moved_q         <= 1'b1;
            line_stable_status_q <= 1'b0;
         end
      end
   end

   // wake activity only counts while the core reports sleep
   assign wake_w = sleeping && armed_w && ((dpm_sync != dpm_prev_q) || pin_edge_w[UOTG_PIN_ID]
                   || pin_edge_w[UOTG_PIN_SESSION_VALID_STATUS] || pin_edge_w[UOTG_PIN_AVBUS]);

   // hardware set terms per flag bit
   always_comb begin
      set_w                  = '0;
      set_w[UOTG_BIT_ID]     = pin_edge_w[UOTG_PIN_ID];
      set_w[UOTG_BIT_TIMER]  = ms_tick;
      set_w[UOTG_BIT_LINE]   = ms_tick && !line_moved_q && !line_step_w && (line_prev_q != line_rec_q);
      set_w[UOTG_BIT_ACT]    = wake_w;
      set_w[UOTG_BIT_SESSION_VALID_STATUS]  = armed_w && b_session_end_status_s && !pin_prev_q[UOTG_PIN_B_SESSION_END_STATUS];
      set_w[UOTG_BIT_B_SESSION_END_STATUS] = pin_edge_w[UOTG_PIN_B_SESSION_END_STATUS];
      set_w[UOTG_BIT_AVBUS]  = pin_edge_w[UOTG_PIN_SESSION_VALID_STATUS];
   end

   // write-one-to-clear on byte lane 0 only
   always_comb begin
      clr_w = '0;
      if (avs_write && ack_q && avs_byteenable[0] && hit(avs_address, UOTG_OFS_FLAGS)) begin
         clr_w = avs_writedata[7:0] & UOTG_FLAG_MASK;
      end
   end

   // set wins over a clear in the same cycle
   always_comb begin
      flags_d = ((flags_q & ~clr_w) | set_w) & UOTG_FLAG_MASK;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flags_q <= UOTG_RESET_VAL;
      end else if (clk_en) begin
         flags_q <= flags_d;
      end
   end

   // live status image
   always_comb begin
      status_w                  = '0;
      status_w[UOTG_BIT_ID]     = id_s;
      status_w[UOTG_BIT_LINE]   = line_stable_status_q;
      status_w[UOTG_BIT_SESSION_VALID_STATUS]  = session_valid_status_s;
      status_w[UOTG_BIT_B_SESSION_END_STATUS] = b_session_end_status_s;
      status_w[UOTG_BIT_AVBUS]  = avbus_s;
   end

   // one wait cycle per access: waitrequest drops in the cycle after request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ack_q <= 1'b0;
      end else if (clk_en) begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

   // registered read data, unmapped reads return zero
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         avs_readdata <= UOTG_ZERO_WORD;
      end else if (clk_en && avs_read && !ack_q) begin
         if (hit(avs_address, UOTG_OFS_FLAGS)) begin
            avs_readdata <= {24'h00_0000, flags_q & UOTG_FLAG_MASK};
         end else if (hit(avs_address, UOTG_OFS_STATUS)) begin
            avs_readdata <= {24'h00_0000, status_w & UOTG_STATUS_MASK};
         end else begin
            avs_readdata <= UOTG_ZERO_WORD;
         end
      end
   end
endmodule : uotg_status

/* sim/uotg_cable.sv */
// uotg_cable: cable far side, drives id, vbus comparator and d+/d- levels
// assumes the bench commands levels; pins move just after a clock edge
`timescale 1ns/1ps
module uotg_cable (
   input  wire logic       ref_clk,
   input  wire logic [5:0] lvl,
   output logic            id_pin,
   output logic            session_valid_in,
   output logic            session_end_in,
   output logic            a_vbus_valid_in,
   output logic            dp_pin,
   output logic            dm_pin
);
   // levels are plain comparator outputs, never released, so no float modelling
   always_ff @(posedge ref_clk) begin
      {id_pin, session_valid_in, session_end_in, a_vbus_valid_in, dp_pin, dm_pin} <= lvl;
   end
endmodule : uotg_cable

/* sim/uotg_status_checker.sv */
// uotg_status_checker: bus and register read rules at the block's ports
// assumes clk_en stays high while requests are open
`timescale 1ns/1ps
module uotg_status_checker
   import uotg_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        clk_en,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        id_pin,
   input wire logic        session_valid_in,
   input wire logic        session_end_in,
   input wire logic        a_vbus_valid_in
);
   logic [3:0] cnt_q;
   logic [3:0] pins_q;
   logic       req;
   assign req = avs_read | avs_write;
   // cycles since the last cable change; live bits lag the sync chain
   always_ff @(posedge ref_clk) begin
      pins_q <= {id_pin, session_valid_in, session_end_in, a_vbus_valid_in};
      if (srst || pins_q != {id_pin, session_valid_in, session_end_in, a_vbus_valid_in}) cnt_q <= 4'h0;
      else if (clk_en && cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);
   sequence st_rd;
      avs_read && !avs_waitrequest && avs_address == UOTG_OFS_STATUS;
   endsequence
   sequence st_settled;
      st_rd ##0 cnt_q > 4'h9;
   endsequence
   AST_ONE_WAIT: assert property (req && avs_waitrequest && clk_en |=> !avs_waitrequest)
      else $error("no answer after one wait state");
   AST_FIRST_WAIT: assert property ($rose(req) |-> avs_waitrequest)
      else $error("request answered without a wait state");
   AST_IDLE: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest without request");
   AST_HIGH_ZERO: assert property (avs_readdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address != UOTG_OFS_FLAGS
      && avs_address != UOTG_OFS_STATUS |-> avs_readdata == UOTG_ZERO_WORD) else $error("unmapped read not zero");
   AST_STAT_RSVD: assert property (st_rd |-> (avs_readdata[7:0] & ~UOTG_STATUS_MASK) == 8'h00)
      else $error("reserved status bit set");
   AST_RD_STAND: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data moved without read");
   AST_ID_LIVE: assert property (st_settled |-> avs_readdata[UOTG_BIT_ID] == id_pin)
      else $error("id status differs from pin");
   AST_VBUS_LIVE: assert property (st_settled |-> {avs_readdata[3:2], avs_readdata[0]} ==
      {session_valid_in, session_end_in, a_vbus_valid_in}) else $error("vbus status differs from pins");
endmodule : uotg_status_checker

bind uotg_status uotg_status_checker u_uotg_status_checker (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .id_pin(id_pin), .session_valid_in(session_valid_in),
   .session_end_in(session_end_in), .a_vbus_valid_in(a_vbus_valid_in));

/* sim/uotg_status_test.sv */
// uotg_status_test: register level test of the otg status block
// assumes the cable model and the bound checker; line state moves once in t_timer
`timescale 1ns/1ps
module uotg_status_test
   import uotg_pkg::*;
;
   logic        ref_clk = 0, srst = 1, clk_en = 1, avs_read = 0, avs_write = 0;
   logic        sleeping = 0, line_se0 = 0, line_j_level = 0, avs_waitrequest;
   logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'h0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
   logic [5:0]  lvl = 6'h00;
   logic        id_pin, session_valid_in, session_end_in, a_vbus_valid_in, dp_pin, dm_pin;
   int          fails = 0, n_checks = 0;
   always #12.5 ref_clk = ~ref_clk;
   uotg_cable u_uotg_cable (.ref_clk(ref_clk), .lvl(lvl), .id_pin(id_pin), .session_valid_in(session_valid_in),
      .session_end_in(session_end_in), .a_vbus_valid_in(a_vbus_valid_in), .dp_pin(dp_pin), .dm_pin(dm_pin));
   uotg_status u_uotg_status (.ref_clk(ref_clk), .srst(srst), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .id_pin(id_pin),
      .session_valid_in(session_valid_in), .session_end_in(session_end_in), .a_vbus_valid_in(a_vbus_valid_in),
      .dp_pin(dp_pin), .dm_pin(dm_pin), .line_se0(line_se0), .line_j_level(line_j_level), .sleeping(sleeping));
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: read %h want %h", $time, got, exp);
      end
   endtask : chk
   // waitrequest sampled at the edge; only the watchdog ends a hung wait
   task automatic wait_ack;
      do begin
         @(posedge ref_clk);
      end while (avs_waitrequest !== 1'b0);
   endtask : wait_ack
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack;
      chk(avs_readdata, exp);
      avs_read <= 1'b0;
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      wait_ack;
      avs_write <= 1'b0;
   endtask : wr
   // new cable levels {id, session_valid_status, b_session_end_status, avbus, dp, dm}, then let syncs settle
   task automatic lv(input logic [5:0] v);
      @(posedge ref_clk);
      lvl <= v;
      repeat (10) @(posedge ref_clk);
   endtask : lv
   task automatic t_idle;
      rd(UOTG_OFS_FLAGS, 32'h0000_0000);
      rd(UOTG_OFS_STATUS, 32'h0000_0000);
      rd(4'h8, 32'h0000_0000);
      $display("t_idle done");
   endtask : t_idle
   task automatic t_id;
      lv(6'b100000);
      rd(UOTG_OFS_FLAGS, 32'h0000_0080);
      rd(UOTG_OFS_STATUS, 32'h0000_0080);
      wr(UOTG_OFS_FLAGS, 32'h0000_00FF, 4'b1110);
      rd(UOTG_OFS_FLAGS, 32'h0000_0080);
      wr(UOTG_OFS_FLAGS, 32'hFFFF_FF00, 4'hF);
      wr(UOTG_OFS_STATUS, 32'hFFFF_FFFF, 4'hF);
      wr(4'h8, 32'hFFFF_FFFF, 4'hF);
      rd(UOTG_OFS_FLAGS, 32'h0000_0080);
      rd(UOTG_OFS_STATUS, 32'h0000_0080);
      wr(UOTG_OFS_FLAGS, 32'h0000_0080, 4'hF);
      rd(UOTG_OFS_FLAGS, 32'h0000_0000);
      $display("t_id done");
   endtask : t_id
   task automatic t_vbus;
      lv(6'b110000);
      rd(UOTG_OFS_FLAGS, 32'h0000_0001);
      rd(UOTG_OFS_STATUS, 32'h0000_0088);
      lv(6'b111000);
      rd(UOTG_OFS_FLAGS, 32'h0000_000D);
      rd(UOTG_OFS_STATUS, 32'h0000_008C);
      lv(6'b111100);
      rd(UOTG_OFS_STATUS, 32'h0000_008D);
      wr(UOTG_OFS_FLAGS, 32'h0000_000D, 4'hF);
      rd(UOTG_OFS_FLAGS, 32'h0000_0000);
      lv(6'b110100);
      rd(UOTG_OFS_FLAGS, 32'h0000_0004);
      wr(UOTG_OFS_FLAGS, 32'h0000_0004, 4'hF);
      $display("t_vbus done");
   endtask : t_vbus
   // activity only counts as a wake while the core sleeps
   task automatic t_act;
      @(posedge ref_clk);
      sleeping <= 1'b1;
      lv(6'b110111);
      rd(UOTG_OFS_FLAGS, 32'h0000_0010);
      sleeping <= 1'b0;
      wr(UOTG_OFS_FLAGS, 32'h0000_0010, 4'hF);
      lv(6'b110100);
      rd(UOTG_OFS_FLAGS, 32'h0000_0000);
      $display("t_act done");
   endtask : t_act
   // mid-run reset with pins idling high must not fake edges; a freeze holds a pin change back
   task automatic t_rst;
      lv(6'b010100);
      srst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      rd(UOTG_OFS_FLAGS, 32'h0000_0000);
      rd(UOTG_OFS_STATUS, 32'h0000_0009);
      @(posedge ref_clk);
      clk_en <= 1'b0;
      lv(6'b110100);
      clk_en <= 1'b1;
      rd(UOTG_OFS_FLAGS, 32'h0000_0000);
      repeat (10) @(posedge ref_clk);
      rd(UOTG_OFS_FLAGS, 32'h0000_0080);
      rd(UOTG_OFS_STATUS, 32'h0000_0089);
      wr(UOTG_OFS_FLAGS, 32'h0000_0080, 4'hF);
      $display("t_rst done");
   endtask : t_rst
   // the line moves once, spoiling the first window; the second window is stable at a new value
   task automatic t_timer;
      @(posedge ref_clk);
      line_j_level <= 1'b1;
      repeat (42000) @(posedge ref_clk);
      rd(UOTG_OFS_STATUS, 32'h0000_0089);
      rd(UOTG_OFS_FLAGS, 32'h0000_0040);
      repeat (42000) @(posedge ref_clk);
      rd(UOTG_OFS_STATUS, 32'h0000_00A9);
      rd(UOTG_OFS_FLAGS, 32'h0000_0060);
      $display("t_timer done");
   endtask : t_timer
   initial begin
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_idle;
      t_id;
      t_vbus;
      t_act;
      t_rst;
      t_timer;
      final_report;
   end
   // watchdog: tests take about 85000 cycles
   initial begin
      repeat (95000) @(posedge ref_clk);
      fails++;
      $display("unexpected at %0t: watchdog expired", $time);
      final_report;
   end
endmodule : uotg_status_test
